// ---- logic/smrc_map.svh ----
`ifndef SMRC_MAP_SVH
`define SMRC_MAP_SVH
`define SMRC_ADDR_CONTROL 15'h7FF8
`define SMRC_ADDR_SECONDS 15'h7FF9
`define SMRC_ADDR_MINUTES 15'h7FFA
`define SMRC_ADDR_HOURS 15'h7FFB
`define SMRC_ADDR_WEEKDAY 15'h7FFC
`define SMRC_ADDR_DATE 15'h7FFD
`define SMRC_ADDR_MONTH 15'h7FFE
`define SMRC_ADDR_YEAR 15'h7FFF
`define SMRC_CTL_SET_BIT 7
`define SMRC_CTL_HOLD_BIT 6
`define SMRC_CTL_SIGN_BIT 5
`define SMRC_SEC_HALT_BIT 7
`define SMRC_DAY_FT_BIT 6
`define SMRC_DAY_CEB_BIT 5
`define SMRC_DAY_CB_BIT 4
`define SMRC_RST_OSC_HALT 1'b1
`define SMRC_RST_DATE 8'h01
`define SMRC_RST_MONTH 8'h01
`define SMRC_RST_WEEKDAY 3'h1
`define SMRC_OSC_HZ 32768
`define SMRC_CLK_HZ 20000000
`define SMRC_SEC_LAST 17'h07FFF
`define SMRC_CAL_SHORTEN 17'h00080
`define SMRC_CAL_LENGTHEN 17'h00100
`define SMRC_CAL_CYCLE_LAST 6'h3F
`define SMRC_TEST_TAP 5
`define SMRC_POWER_UP_RECOVERY_TIME_MS 40
`define SMRC_POWER_UP_RECOVERY_TIME_CYCLES (`SMRC_POWER_UP_RECOVERY_TIME_MS * (`SMRC_CLK_HZ / 1000))
`endif

// ---- logic/smrc_pkg.sv ----
package smrc_pkg;
  typedef enum logic [1:0] {
    SMRC_PWR_READY = 2'b00,
    SMRC_PWR_DOWN = 2'b01,
    SMRC_PWR_RECOVER = 2'b10
  } smrc_pwr_t;
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [14:0] addr;
    logic [7:0] wdata;
  } smrc_bus_in_t;
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hr;
    logic [2:0] dow;
    logic [7:0] date;
    logic [7:0] mon;
    logic [7:0] yr;
    logic cb;
  } smrc_time_t;
  typedef struct packed {
    logic set_bit;
    logic hold_bit;
    logic sign;
    logic [4:0] cal;
  } smrc_ctl_t;
endpackage

// ---- logic/smrc_mem.sv ----
`timescale 1ns/1ns
`default_nettype none
module smrc_mem
(
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [14:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem_q [0:32767];
  logic [7:0] rdata_ff;

  // Array content is not reset, as with any static memory.
  always_ff @(posedge ref_clk)
  begin
    if (wr_en)
    begin
      mem_q[addr] <= wdata;
    end
    rdata_ff <= mem_q[addr];
  end

  assign rdata = rdata_ff;
endmodule
`default_nettype wire

// ---- logic/smrc_core.sv ----
// Notes on behaviour
// - Power fail deselects, floats data, ignores bus.
// - Power fail corrupts at most addressed byte.
// - Bus stays blocked for recovery time afterwards.
// - Hold bit set stops mirror updates.
// - Held mirror shows time at hold; counters run.
// - Mirror updates all bytes in one step.
// - Mirror refreshed within a second after hold clears.
// - Set bit freezes; clearing loads counters from mirror.
// - Next update within one second after set clears.
// - Halt bit stops oscillator, reset set, restarts.
// - Century flag toggles at rollover when enabled.
// - Enable always writable; flag only under set bit.
// - Control holds calibration magnitude and sign bit.
// - Calibration adds or blanks divider stage pulses.
// - First 2N minutes of 64 get one altered second.
// - Counters run from 32768 Hz oscillator ticks.
// - Test bit toggles data bit zero at 512 Hz.
// - Test output ignores calibration setting.
// - Test bit cleared automatically at power-down.
// - Clock bytes on top eight addresses, rest memory.
// - Month lengths and leap February handled.
`timescale 1ns/1ns
`default_nettype none
`include "smrc_map.svh"
module smrc_core
#(
  parameter int unsigned REC_CYCLES = `SMRC_POWER_UP_RECOVERY_TIME_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic osc_tick,
  input wire logic power_fail,
  input wire smrc_pkg::smrc_bus_in_t bus_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic access_ready
);
  import smrc_pkg::*;

  typedef struct packed {
    smrc_pwr_t pwr;
    logic [19:0] rec_cnt;
    logic ready;
    smrc_ctl_t ctl;
    logic osc_halt;
    logic ft;
    logic ceb;
    smrc_time_t cnt;
    smrc_time_t mir;
    logic [16:0] pre;
    logic [5:0] raw;
    logic [5:0] cal_min;
    logic rd_v;
    logic rd_clk;
    logic [7:0] rd_byte;
    logic [7:0] dout;
    logic oe;
  } smrc_state_t;

  smrc_state_t st_ff;
  smrc_state_t nxt_st;
  logic [7:0] mem_rdata;
  logic bus_ok;
  logic wr_en;
  logic rd_en;
  logic is_clk;

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
    begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end
    else
    begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // BCD year divisible by four; the rule ends at 2100 as the part does.
  function automatic logic is_leap(input logic [7:0] y);
    if (y[4] == 1'b0)
    begin
      is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
    else
    begin
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end
  endfunction

  function automatic logic [7:0] last_date(input logic [7:0] m, input logic [7:0] y);
    case (m)
      8'h02: last_date = is_leap(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_date = 8'h30;
      default: last_date = 8'h31;
    endcase
  endfunction

  // Whole cascade in one function so every field moves in the same edge.
  function automatic smrc_time_t advance(input smrc_time_t c, input logic en_cent);
    smrc_time_t t;
    t = c;
    if (t.sec != 8'h59)
    begin
      t.sec = bcd_inc(t.sec);
    end
    else
    begin
      t.sec = 8'h00;
      if (t.min != 8'h59)
      begin
        t.min = bcd_inc(t.min);
      end
      else
      begin
        t.min = 8'h00;
        if (t.hr != 8'h23)
        begin
          t.hr = bcd_inc(t.hr);
        end
        else
        begin
          t.hr = 8'h00;
          t.dow = (t.dow >= 3'h7) ? 3'h1 : t.dow + 3'h1;
          if (t.date < last_date(t.mon, t.yr))
          begin
            t.date = bcd_inc(t.date);
          end
          else
          begin
            t.date = 8'h01;
            if (t.mon < 8'h12)
            begin
              t.mon = bcd_inc(t.mon);
            end
            else
            begin
              t.mon = 8'h01;
              if (t.yr != 8'h99)
              begin
                t.yr = bcd_inc(t.yr);
              end
              else
              begin
                t.yr = 8'h00;
                t.cb = en_cent ? ~t.cb : t.cb;
              end
            end
          end
        end
      end
    end
    advance = t;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  smrc_mem u_mem
  (
    .ref_clk(ref_clk),
    .wr_en(wr_en && !is_clk),
    .addr(bus_in.addr),
    .wdata(bus_in.wdata),
    .rdata(mem_rdata)
  );

  assign is_clk = (bus_in.addr >= `SMRC_ADDR_CONTROL);
  // The fail flag gates the bus in the same cycle it rises, so a write in
  // flight can only touch the byte it already addressed.
  assign bus_ok = st_ff.ready && !power_fail;
  assign wr_en = bus_ok && !bus_in.ce_n && !bus_in.we_n;
  assign rd_en = bus_ok && !bus_in.ce_n && !bus_in.oe_n && bus_in.we_n;

  always_comb
  begin
    logic sec_tick;
    logic adj;
    logic [16:0] limit;
    smrc_time_t adv;
    sec_tick = 1'b0;
    adj = 1'b0;
    limit = `SMRC_SEC_LAST;
    adv = st_ff.cnt;
    nxt_st = st_ff;

    // Power sequencing.
    case (st_ff.pwr)
      SMRC_PWR_READY:
      begin
        if (power_fail)
        begin
          nxt_st.pwr = SMRC_PWR_DOWN;
          nxt_st.ready = 1'b0;
          nxt_st.ft = 1'b0;
        end
      end
      SMRC_PWR_DOWN:
      begin
        nxt_st.ready = 1'b0;
        if (!power_fail)
        begin
          nxt_st.pwr = SMRC_PWR_RECOVER;
          nxt_st.rec_cnt = 20'h00000;
        end
      end
      SMRC_PWR_RECOVER:
      begin
        if (power_fail)
        begin
          nxt_st.pwr = SMRC_PWR_DOWN;
        end
        else if (st_ff.rec_cnt >= 20'(REC_CYCLES - 1))
        begin
          nxt_st.pwr = SMRC_PWR_READY;
          nxt_st.ready = 1'b1;
        end
        else
        begin
          nxt_st.rec_cnt = st_ff.rec_cnt + 20'h00001;
        end
      end
      default:
      begin
        nxt_st.pwr = SMRC_PWR_DOWN;
        nxt_st.ready = 1'b0;
      end
    endcase

    // Divider and calibration.
    if (osc_tick && !st_ff.osc_halt)
    begin
      nxt_st.raw = st_ff.raw + 6'h01;
      adj = (st_ff.cnt.sec == 8'h00) && (st_ff.cal_min < {st_ff.ctl.cal, 1'b0});
      if (adj)
      begin
        limit = st_ff.ctl.sign ? `SMRC_SEC_LAST - `SMRC_CAL_SHORTEN
                               : `SMRC_SEC_LAST + `SMRC_CAL_LENGTHEN;
      end
      if (st_ff.pre >= limit)
      begin
        nxt_st.pre = 17'h00000;
        sec_tick = 1'b1;
      end
      else
      begin
        nxt_st.pre = st_ff.pre + 17'h00001;
      end
    end

    if (sec_tick)
    begin
      adv = advance(st_ff.cnt, st_ff.ceb);
      nxt_st.cnt = adv;
      if (st_ff.cnt.sec == 8'h59)
      begin
        nxt_st.cal_min = (st_ff.cal_min == `SMRC_CAL_CYCLE_LAST) ? 6'h00
                         : st_ff.cal_min + 6'h01;
      end
      // A hold set in this same cycle still lets this copy finish.
      if (!st_ff.ctl.hold_bit && !st_ff.ctl.set_bit)
      begin
        nxt_st.mir = adv;
      end
    end

    // Register writes.
    if (wr_en && is_clk)
    begin
      case (bus_in.addr)
        `SMRC_ADDR_CONTROL:
        begin
          nxt_st.ctl = bus_in.wdata;
          if (st_ff.ctl.set_bit && !bus_in.wdata[`SMRC_CTL_SET_BIT])
          begin
            nxt_st.cnt = st_ff.mir;
            nxt_st.pre = 17'h00000;
          end
        end
        `SMRC_ADDR_SECONDS:
        begin
          nxt_st.osc_halt = bus_in.wdata[`SMRC_SEC_HALT_BIT];
          nxt_st.mir.sec = {1'b0, bus_in.wdata[6:0]};
        end
        `SMRC_ADDR_MINUTES: nxt_st.mir.min = {1'b0, bus_in.wdata[6:0]};
        `SMRC_ADDR_HOURS: nxt_st.mir.hr = {2'b00, bus_in.wdata[5:0]};
        `SMRC_ADDR_WEEKDAY:
        begin
          nxt_st.ft = bus_in.wdata[`SMRC_DAY_FT_BIT];
          nxt_st.ceb = bus_in.wdata[`SMRC_DAY_CEB_BIT];
          if (st_ff.ctl.set_bit)
          begin
            nxt_st.mir.cb = bus_in.wdata[`SMRC_DAY_CB_BIT];
          end
          nxt_st.mir.dow = bus_in.wdata[2:0];
        end
        `SMRC_ADDR_DATE: nxt_st.mir.date = {2'b00, bus_in.wdata[5:0]};
        `SMRC_ADDR_MONTH: nxt_st.mir.mon = {3'b000, bus_in.wdata[4:0]};
        `SMRC_ADDR_YEAR: nxt_st.mir.yr = bus_in.wdata;
        default: nxt_st.ctl = st_ff.ctl;
      endcase
    end

    // Two-stage read path: the memory answers one cycle after the address.
    nxt_st.rd_v = rd_en;
    nxt_st.rd_clk = is_clk;
    case (bus_in.addr)
      `SMRC_ADDR_CONTROL: nxt_st.rd_byte = st_ff.ctl;
      `SMRC_ADDR_SECONDS:
      begin
        nxt_st.rd_byte = {st_ff.osc_halt, st_ff.mir.sec[6:0]};
        if (st_ff.ft && !st_ff.osc_halt)
        begin
          nxt_st.rd_byte[0] = st_ff.raw[`SMRC_TEST_TAP];
        end
      end
      `SMRC_ADDR_MINUTES: nxt_st.rd_byte = st_ff.mir.min;
      `SMRC_ADDR_HOURS: nxt_st.rd_byte = st_ff.mir.hr;
      `SMRC_ADDR_WEEKDAY:
        nxt_st.rd_byte = {1'b0, st_ff.ft, st_ff.ceb, st_ff.mir.cb, 1'b0, st_ff.mir.dow};
      `SMRC_ADDR_DATE: nxt_st.rd_byte = st_ff.mir.date;
      `SMRC_ADDR_MONTH: nxt_st.rd_byte = st_ff.mir.mon;
      `SMRC_ADDR_YEAR: nxt_st.rd_byte = st_ff.mir.yr;
      default: nxt_st.rd_byte = 8'h00;
    endcase
    // Idle cycles show zero, so the unreset array leaks unknowns out only when an unwritten byte is read.
    nxt_st.dout = !st_ff.rd_v ? 8'h00 : st_ff.rd_clk ? st_ff.rd_byte : mem_rdata;
    nxt_st.oe = st_ff.rd_v && rd_en;

    if (rst)
    begin
      nxt_st = '0;
      nxt_st.pwr = SMRC_PWR_READY;
      nxt_st.ready = 1'b1;
      nxt_st.osc_halt = `SMRC_RST_OSC_HALT;
      nxt_st.cnt.date = `SMRC_RST_DATE;
      nxt_st.cnt.mon = `SMRC_RST_MONTH;
      nxt_st.cnt.dow = `SMRC_RST_WEEKDAY;
      nxt_st.mir = nxt_st.cnt;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    st_ff <= nxt_st;
  end

  assign data_out = st_ff.dout;
  assign data_oe = st_ff.oe;
  assign access_ready = st_ff.ready;
endmodule
`default_nettype wire

// ---- tb/smrc_core_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module smrc_core_chk
#(
  parameter int unsigned REC_CYCLES = 20
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic osc_tick,
  input wire logic power_fail,
  input wire smrc_pkg::smrc_bus_in_t bus_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic access_ready
);
  import smrc_pkg::*;
  logic rd;
  assign rd = !bus_in.ce_n && !bus_in.oe_n && bus_in.we_n && access_ready && !power_fail;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  chk_fail_float: assert property (power_fail |=> !data_oe)
    else $error("data driven after power fail");
  chk_fail_block: assert property (power_fail |=> !access_ready)
    else $error("bus accepted during power fail");
  chk_rec_low: assert property ($fell(power_fail) |-> !access_ready [*8])
    else $error("bus accepted too early after power return");
  chk_rec_bound: assert property ($fell(power_fail) |-> ##[1:40] access_ready)
    else $error("bus not accepted after recovery");
  chk_ready_keep: assert property (access_ready && !power_fail |=> access_ready)
    else $error("bus dropped without power fail");
  chk_ready_rst: assert property ($fell(rst) |-> access_ready)
    else $error("bus not ready after reset");
  chk_read_lat: assert property (rd ##1 rd |=> data_oe)
    else $error("read data not driven");
  chk_oe_cause: assert property (data_oe |-> $past(rd, 1) || $past(rd, 2) || $past(rd, 3))
    else $error("data driven without a read");
endmodule
bind smrc_core smrc_core_chk #(.REC_CYCLES(REC_CYCLES)) i_smrc_core_chk
(
  .ref_clk(ref_clk),
  .rst(rst),
  .osc_tick(osc_tick),
  .power_fail(power_fail),
  .bus_in(bus_in),
  .data_out(data_out),
  .data_oe(data_oe),
  .access_ready(access_ready)
);
`default_nettype wire

// ---- tb/smrc_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module smrc_host_model
(
  input wire logic ref_clk,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output var smrc_pkg::smrc_bus_in_t bus_in
);
  import smrc_pkg::*;
  // Chip select stays inactive from power-up until the first access.
  initial bus_in = '{1'b1, 1'b1, 1'b1, 15'h0000, 8'h00};
  // Deselected lines are inverted so a stale address can never look valid.
  task automatic idle();
    bus_in = '{1'b1, 1'b1, 1'b1, ~bus_in.addr, ~bus_in.wdata};
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    bus_in = '{1'b0, 1'b1, 1'b0, a, d};
    @(negedge ref_clk);
    idle();
  endtask
  task automatic rd(input logic [14:0] a, output logic [7:0] d, output logic oe);
    @(negedge ref_clk);
    bus_in = '{1'b0, 1'b0, 1'b1, a, 8'h00};
    repeat (3) @(negedge ref_clk);
    d = data_out;
    oe = data_oe;
    @(negedge ref_clk);
    idle();
  endtask
endmodule
`default_nettype wire

// ---- tb/smrc_core_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module smrc_core_tb;
  import smrc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic osc_tick = 1'b0;
  logic power_fail = 1'b0;
  smrc_bus_in_t bus_in;
  logic [7:0] data_out;
  logic data_oe;
  logic access_ready;
  int n_errors = 0;
  int n_checks = 0;
  logic [7:0] exp_tm [7] = '{8'h01, 8'h00, 8'h00, 8'h31, 8'h01, 8'h03, 8'h23};
  always #25 ref_clk = ~ref_clk;
  // A short recovery count keeps the run brief; the checks hard-code bounds that fit it.
  smrc_core #(.REC_CYCLES(20)) i_smrc_core
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .osc_tick(osc_tick),
    .power_fail(power_fail),
    .bus_in(bus_in),
    .data_out(data_out),
    .data_oe(data_oe),
    .access_ready(access_ready)
  );
  smrc_host_model i_smrc_host_model
  (
    .ref_clk(ref_clk),
    .data_out(data_out),
    .data_oe(data_oe),
    .bus_in(bus_in)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [14:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic oe;
    i_smrc_host_model.rd(a, d, oe);
    check({7'h00, oe}, 8'h01);
    check(d, exp);
  endtask
  task automatic finish_test();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_ram();
    i_smrc_host_model.wr(15'h0123, 8'hA5);
    i_smrc_host_model.wr(15'h0124, 8'h5A);
    rdchk(15'h0123, 8'hA5);
    rdchk(15'h0124, 8'h5A);
    rdchk(15'h7FF8, 8'h00);
    rdchk(15'h7FF9, 8'h80);
    $display("test ram done");
  endtask
  // Last second of a non-leap February, Sunday, so every counter up to the month rolls.
  // A speed-up calibration of one takes 128 cycles off the next second;
  // the reads sit in the gap this opens, so an uncorrected second fails.
  task automatic test_clock();
    i_smrc_host_model.wr(15'h7FF8, 8'h80);
    i_smrc_host_model.wr(15'h7FF9, 8'h59);
    i_smrc_host_model.wr(15'h7FFA, 8'h59);
    i_smrc_host_model.wr(15'h7FFB, 8'h23);
    i_smrc_host_model.wr(15'h7FFC, 8'h37);
    i_smrc_host_model.wr(15'h7FFD, 8'h28);
    i_smrc_host_model.wr(15'h7FFE, 8'h02);
    i_smrc_host_model.wr(15'h7FFF, 8'h23);
    i_smrc_host_model.wr(15'h7FF8, 8'h00);
    i_smrc_host_model.wr(15'h7FF8, 8'h61);
    repeat (40000) @(negedge ref_clk);
    rdchk(15'h7FF9, 8'h59);
    i_smrc_host_model.wr(15'h7FF8, 8'h21);
    repeat (25460) @(negedge ref_clk);
    for (int i = 0; i < 7; i++)
      rdchk(15'h7FF9 + 15'(i), exp_tm[i]);
    rdchk(15'h7FF8, 8'h21);
    $display("test clock done");
  endtask
  task automatic test_power();
    logic [7:0] d;
    logic [7:0] d2;
    logic oe;
    int n;
    i_smrc_host_model.wr(15'h7FFC, 8'h41);
    // Two reads whose sample points lie 32 oscillator ticks apart.
    i_smrc_host_model.rd(15'h7FF9, d, oe);
    repeat (27) @(negedge ref_clk);
    i_smrc_host_model.rd(15'h7FF9, d2, oe);
    check({7'h00, d[0] ^ d2[0]}, 8'h01);
    @(negedge ref_clk);
    power_fail = 1'b1;
    i_smrc_host_model.wr(15'h0124, 8'hFF);
    i_smrc_host_model.rd(15'h0124, d, oe);
    check({7'h00, oe}, 8'h00);
    check({7'h00, access_ready}, 8'h00);
    @(negedge ref_clk);
    power_fail = 1'b0;
    n = 0;
    while (access_ready !== 1'b1 && n < 100)
    begin
      @(negedge ref_clk);
      n++;
    end
    check({7'h00, access_ready}, 8'h01);
    if (n == 100)
      finish_test();
    check(8'(n >= 19), 8'h01);
    rdchk(15'h0124, 8'h5A);
    rdchk(15'h7FFC, 8'h11);
    $display("test power done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    // One tick per clock shortens a second to 32768 cycles.
    osc_tick = 1'b1;
    test_ram();
    test_clock();
    test_power();
    finish_test();
  end
endmodule
`default_nettype wire
